/* hdl/fet_fault_supervisor_defines.svh */
// register offsets, field positions, reset values and timing counts
// assumes a 100 MHz pclk; included by bare name
`ifndef FET_FAULT_SUPERVISOR_DEFINES_SVH
`define FET_FAULT_SUPERVISOR_DEFINES_SVH

`define FFS_OFF_CTRL      8'h00
`define FFS_OFF_STATUS    8'h04
`define FFS_OFF_IRQ_MASK  8'h08
`define FFS_OFF_FLT_MASK  8'h0C
`define FFS_OFF_OT_THR    8'h10
`define FFS_OFF_TEMP      8'h14
`define FFS_OFF_GPIO_CFG  8'h18
`define FFS_OFF_GPIO_DATA 8'h1C
`define FFS_OFF_STATE     8'h20

`define FFS_CTRL_SW_EN    0
`define FFS_CTRL_RETRY    1
`define FFS_CTRL_DS_DIS   2
`define FFS_CTRL_RESTART  3

`define FFS_ST_SPF 0
`define FFS_ST_OT  1
`define FFS_ST_DS  2
`define FFS_ST_GD  3
`define FFS_ST_GS  4
`define FFS_ST_OC  5
`define FFS_STAT_W 6

`define FFS_CTRL_RST     4'h1
`define FFS_OT_THR_RST   8'hFF
`define FFS_GPIO_CFG_RST 16'h5032

`define FFS_CLK_NS      10
`define FFS_GS_DLY_NS   10000
`define FFS_GS_DLY_CYC  ((`FFS_GS_DLY_NS + `FFS_CLK_NS - 1) / `FFS_CLK_NS)
`define FFS_SU_TMR_US   2000
`define FFS_SU_TMR_CYC  (`FFS_SU_TMR_US * 1000 / `FFS_CLK_NS)
`define FFS_DS_TMR_US   1000
`define FFS_DS_TMR_CYC  (`FFS_DS_TMR_US * 1000 / `FFS_CLK_NS)
`define FFS_RETRY_US    100000
`define FFS_RETRY_CYC   (`FFS_RETRY_US * 1000 / `FFS_CLK_NS)

`endif

/* hdl/ffs_pkg.sv */
// types shared by the fet fault supervisor
// no assumptions beyond a single pclk domain
package ffs_pkg;

  typedef enum logic [2:0] {
    ST_OFF    = 3'b000,
    ST_CHECK  = 3'b001,
    ST_DISCH  = 3'b010,
    ST_START  = 3'b011,
    ST_STEADY = 3'b100,
    ST_FAULT  = 3'b101
  } sup_state_e;

  typedef enum logic [3:0] {
    FN_DIN    = 4'h0,
    FN_DOUT   = 4'h1,
    FN_FAULT  = 4'h2,
    FN_PGOOD  = 4'h3,
    FN_SWITCH_ENABLE_IO   = 4'h4,
    FN_ALERT  = 4'h5,
    FN_CMP1   = 4'h6,
    FN_CMP2   = 4'h7,
    FN_EEPROM_CLOCK_LINE  = 4'h8,
    FN_EEPROM_DATA_LINE = 4'h9
  } gpio_fn_e;

  // analog comparator levels, asynchronous to pclk
  typedef struct packed {
    logic enable_pin;
    logic backup_oc;
    logic current_reference_pin_gnd;
    logic tj_over;
    logic vds_small;
    logic vout_low;
    logic gate_near_vin;
    logic gs_ok;
    logic cmp1;
    logic cmp2;
  } sense_s;

endpackage

/* hdl/ffs_sync2.sv */
// two flip-flop level synchroniser
// inputs are asynchronous levels; only stage two is read outside
`timescale 1ns/1ps
module ffs_sync2 #(
  parameter int unsigned W = 1
) (
  input  wire logic         pclk,    // clock
  input  wire logic         presetn, // async reset, active low
  input  wire logic [W-1:0] d,       // asynchronous input
  output logic      [W-1:0] q        // synchronised output
);
  logic [W-1:0] meta_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule

/* hdl/fet_fault_supervisor.sv */
// fet fault supervisor: protection sequencing, flags and apb registers
// assumes comparator levels are async, adc codes share pclk
`timescale 1ns/1ps
`include "fet_fault_supervisor_defines.svh"
module fet_fault_supervisor #(
  parameter int unsigned SU_TMR_CYC = `FFS_SU_TMR_CYC,
  parameter int unsigned DS_TMR_CYC = `FFS_DS_TMR_CYC,
  parameter int unsigned RETRY_CYC  = `FFS_RETRY_CYC,
  parameter int unsigned CUR_W      = 12
) (
  input  wire logic             pclk,          // clock
  input  wire logic             presetn,       // async reset, active low
  input  wire logic             psel,          // apb select
  input  wire logic             penable,       // apb enable
  input  wire logic             pwrite,        // apb write
  input  wire logic [7:0]       paddr,         // apb byte address
  input  wire logic [31:0]      pwdata,        // apb write data
  output logic      [31:0]      prdata,        // apb read data
  output logic                  pready,        // apb ready
  output logic                  pslverr,       // apb error
  input  wire ffs_pkg::sense_s  sense_raw,     // comparator levels
  input  wire logic [7:0]       temp_code,     // die temperature adc
  input  wire logic [CUR_W-1:0] current_code,  // load current adc
  input  wire logic [CUR_W-1:0] current_reference_pin_code,     // reference adc
  input  wire logic [3:0]       gpio_i,        // pin levels
  output logic      [3:0]       gpio_o,        // pin drive values
  output logic      [3:0]       gpio_oe,       // pin drive enables
  output logic                  gate_drive_on, // gate driver enable
  output logic                  discharge_en,  // output discharge
  output logic                  fault_output_n,// fault pin, low active
  output logic                  smb_alert_n,   // alert, low active
  output logic                  irq,           // interrupt, high
  output logic                  power_good_output,    // power good
  output logic [CUR_W-1:0]      load_current_monitor  // load current
);
  localparam int unsigned TW = 24;
  localparam logic [TW-1:0] GS_DLY = TW'(`FFS_GS_DLY_CYC);

  ffs_pkg::sense_s sn;
  logic [3:0]      gpio_s;

  ffs_sync2 #(.W($bits(ffs_pkg::sense_s))) u_sync_sense (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (sense_raw),
    .q       (sn)
  );
  ffs_sync2 #(.W(4)) u_sync_gpio (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (gpio_i),
    .q       (gpio_s)
  );

  // registers
  logic [3:0]             ctrl_q;
  logic [`FFS_STAT_W-1:0] status_q;
  logic [`FFS_STAT_W-1:0] irq_mask_q;
  logic [`FFS_STAT_W-1:0] flt_mask_q;
  logic [7:0]             ot_thr_q;
  logic [7:0]             temp_q;
  logic [15:0]            gpio_cfg_q;
  logic [3:0]             gpio_out_q;
  ffs_pkg::sup_state_e    state_q;
  logic [TW-1:0]          tmr_q;
  logic [TW-1:0]          gs_cnt_q;

  // apb
  logic wr_acc;
  logic rd_acc;
  logic restart;
  assign wr_acc  = psel & penable & pready & pwrite;
  assign rd_acc  = psel & penable & ~pready & ~pwrite;
  assign restart = wr_acc & (paddr == `FFS_OFF_CTRL)
                   & pwdata[`FFS_CTRL_RESTART];

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'h0) && (a <= `FFS_OFF_STATE);
  endfunction

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~mapped(paddr);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_acc) begin
      case (paddr)
        `FFS_OFF_CTRL:      prdata <= {29'h0, ctrl_q[2:0]};
        `FFS_OFF_STATUS:    prdata <= {26'h0, status_q};
        `FFS_OFF_IRQ_MASK:  prdata <= {26'h0, irq_mask_q};
        `FFS_OFF_FLT_MASK:  prdata <= {26'h0, flt_mask_q};
        `FFS_OFF_OT_THR:    prdata <= {24'h0, ot_thr_q};
        `FFS_OFF_TEMP:      prdata <= {24'h0, temp_q};
        `FFS_OFF_GPIO_CFG:  prdata <= {16'h0, gpio_cfg_q};
        `FFS_OFF_GPIO_DATA: prdata <= {24'h0, gpio_s, gpio_out_q};
        `FFS_OFF_STATE:     prdata <= {27'h0, power_good_output,
                                       gate_drive_on, state_q};
        default:            prdata <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q     <= `FFS_CTRL_RST;
      irq_mask_q <= '0;
      flt_mask_q <= '0;
      ot_thr_q   <= `FFS_OT_THR_RST;
      gpio_cfg_q <= `FFS_GPIO_CFG_RST;
      gpio_out_q <= 4'hF;
    end else if (wr_acc) begin
      case (paddr)
        `FFS_OFF_CTRL:      ctrl_q <= {1'b0, pwdata[2:0]};
        `FFS_OFF_IRQ_MASK:  irq_mask_q <= pwdata[`FFS_STAT_W-1:0];
        `FFS_OFF_FLT_MASK:  flt_mask_q <= pwdata[`FFS_STAT_W-1:0];
        `FFS_OFF_OT_THR:    ot_thr_q <= pwdata[7:0];
        `FFS_OFF_GPIO_CFG:  gpio_cfg_q <= pwdata[15:0];
        `FFS_OFF_GPIO_DATA: gpio_out_q <= pwdata[3:0];
        default:            ;
      endcase
    end
  end

  // telemetry sample
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      temp_q <= 8'h00;
    end else begin
      temp_q <= temp_code;
    end
  end

  // fault detection
  logic             enabled;
  logic             gate_cmd;
  logic [CUR_W-1:0] trip_thr;
  logic             primary_trip;
  logic             spf_det;
  logic             ot_det;
  logic             gd_det;
  logic             tmr_done;
  logic             gs_low_done;
  logic             ds_to;
  logic             gs_to;
  logic             any_fault;
  logic [`FFS_STAT_W-1:0] set_vec;

  assign enabled  = ctrl_q[`FFS_CTRL_SW_EN] & sn.enable_pin;
  assign gate_cmd = (state_q == ffs_pkg::ST_START)
                    | (state_q == ffs_pkg::ST_STEADY);
  assign trip_thr = sn.current_reference_pin_gnd ? '0 : current_reference_pin_code;
  assign primary_trip = gate_cmd & (current_code > trip_thr);
  assign spf_det  = gate_cmd & sn.backup_oc & ~primary_trip;
  // internal sensor and adc code only, external pin never used
  assign ot_det   = sn.tj_over | (temp_code >= ot_thr_q);
  assign gd_det   = sn.gate_near_vin & ~gate_cmd;
  assign tmr_done = (tmr_q == '0);
  assign ds_to    = (state_q == ffs_pkg::ST_DISCH) & tmr_done
                    & ~sn.vout_low;
  assign gs_to    = (state_q == ffs_pkg::ST_START) & tmr_done
                    & ~sn.gs_ok;
  assign gs_low_done = (state_q == ffs_pkg::ST_STEADY)
                       & (gs_cnt_q == GS_DLY);

  always_comb begin
    set_vec = '0;
    set_vec[`FFS_ST_SPF] = spf_det;
    set_vec[`FFS_ST_OT]  = ot_det;
    set_vec[`FFS_ST_DS]  = ds_to;
    set_vec[`FFS_ST_GD]  = gd_det;
    set_vec[`FFS_ST_GS]  = gs_to | gs_low_done;
    set_vec[`FFS_ST_OC]  = primary_trip & (state_q == ffs_pkg::ST_STEADY);
  end
  assign any_fault = |set_vec;

  // sticky flags: write one clears, restart clears, set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_q <= '0;
    end else begin
      status_q <= (status_q
                   & ~(wr_acc && paddr == `FFS_OFF_STATUS ?
                       pwdata[`FFS_STAT_W-1:0] : '0)
                   & ~{`FFS_STAT_W{restart}})
                  | set_vec;
    end
  end

  // steady-state gate-source drop deglitch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gs_cnt_q <= '0;
    end else if (state_q != ffs_pkg::ST_STEADY || sn.gs_ok) begin
      gs_cnt_q <= '0;
    end else if (gs_cnt_q != GS_DLY) begin
      gs_cnt_q <= gs_cnt_q + TW'(1);
    end
  end

  // sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ffs_pkg::ST_OFF;
      tmr_q   <= '0;
    end else if (!enabled) begin
      state_q <= ffs_pkg::ST_OFF;
      tmr_q   <= '0;
    end else begin
      if (!tmr_done) begin
        tmr_q <= tmr_q - TW'(1);
      end
      case (state_q)
        ffs_pkg::ST_OFF: begin
          if (!ot_det && !gd_det) begin
            state_q <= ffs_pkg::ST_CHECK;
          end
        end
        ffs_pkg::ST_CHECK: begin
          if (any_fault) begin
            state_q <= ffs_pkg::ST_FAULT;
            tmr_q   <= TW'(RETRY_CYC);
          end else if (!ctrl_q[`FFS_CTRL_DS_DIS] && sn.vds_small) begin
            state_q <= ffs_pkg::ST_DISCH;
            tmr_q   <= TW'(DS_TMR_CYC);
          end else begin
            state_q <= ffs_pkg::ST_START;
            tmr_q   <= TW'(SU_TMR_CYC);
          end
        end
        ffs_pkg::ST_DISCH: begin
          if (any_fault) begin
            state_q <= ffs_pkg::ST_FAULT;
            tmr_q   <= TW'(RETRY_CYC);
          end else if (sn.vout_low) begin
            state_q <= ffs_pkg::ST_START;
            tmr_q   <= TW'(SU_TMR_CYC);
          end
        end
        ffs_pkg::ST_START: begin
          if (any_fault) begin
            state_q <= ffs_pkg::ST_FAULT;
            tmr_q   <= TW'(RETRY_CYC);
          end else if (sn.gs_ok) begin
            state_q <= ffs_pkg::ST_STEADY;
          end
        end
        ffs_pkg::ST_STEADY: begin
          if (any_fault) begin
            state_q <= ffs_pkg::ST_FAULT;
            tmr_q   <= TW'(RETRY_CYC);
          end
        end
        ffs_pkg::ST_FAULT: begin
          if (restart) begin
            state_q <= ffs_pkg::ST_OFF;
          end else if (ctrl_q[`FFS_CTRL_RETRY] && tmr_done
                       && !ot_det) begin
            state_q <= ffs_pkg::ST_OFF;
          end
        end
        default: state_q <= ffs_pkg::ST_OFF;
      endcase
    end
  end

  // pin drives
  logic             alert;
  logic             fault_ind;
  logic             pg_next;
  logic             gate_next;

  assign alert     = |(status_q & ~irq_mask_q);
  assign fault_ind = |(status_q & ~flt_mask_q);
  assign pg_next   = (state_q == ffs_pkg::ST_STEADY) & ~any_fault;
  assign gate_next = gate_cmd & ~any_fault;

  function automatic logic [1:0] pin_drive(input logic [3:0] fn,
                                           input logic       dout);
    pin_drive = 2'b00;
    case (fn)
      ffs_pkg::FN_DOUT:   pin_drive = {1'b1, dout};
      ffs_pkg::FN_FAULT:  pin_drive = {fault_ind, 1'b0};
      ffs_pkg::FN_PGOOD:  pin_drive = {1'b1, pg_next};
      ffs_pkg::FN_SWITCH_ENABLE_IO:   pin_drive = {state_q == ffs_pkg::ST_FAULT, 1'b0};
      ffs_pkg::FN_ALERT:  pin_drive = {alert, 1'b0};
      ffs_pkg::FN_CMP1:   pin_drive = {1'b1, sn.cmp1};
      ffs_pkg::FN_CMP2:   pin_drive = {1'b1, sn.cmp2};
      ffs_pkg::FN_EEPROM_CLOCK_LINE:  pin_drive = {~dout, 1'b0};
      ffs_pkg::FN_EEPROM_DATA_LINE: pin_drive = {~dout, 1'b0};
      default:            pin_drive = 2'b00;
    endcase
  endfunction

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gpio_o  <= 4'h0;
      gpio_oe <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        {gpio_oe[i], gpio_o[i]} <=
          pin_drive(gpio_cfg_q[4*i +: 4], gpio_out_q[i]);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_drive_on     <= 1'b0;
      discharge_en      <= 1'b0;
      fault_output_n    <= 1'b1;
      smb_alert_n       <= 1'b1;
      irq               <= 1'b0;
      power_good_output <= 1'b0;
    end else begin
      gate_drive_on     <= enabled & gate_next;
      discharge_en      <= enabled & (state_q == ffs_pkg::ST_DISCH);
      fault_output_n    <= ~fault_ind;
      smb_alert_n       <= ~alert;
      irq               <= alert;
      power_good_output <= enabled & pg_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      load_current_monitor <= '0;
    end else if (state_q == ffs_pkg::ST_STEADY) begin
      load_current_monitor <= current_code;
    end else begin
      load_current_monitor <= '0;
    end
  end

endmodule

/* test/fet_fault_supervisor_asserts.sv */
// port checker for the fet fault supervisor
// bound to every instance; single pclk domain
`timescale 1ns/1ps
module fet_fault_supervisor_asserts #(
  parameter int unsigned CUR_W = 12
) (
  input wire logic             pclk,                // clock
  input wire logic             presetn,             // reset
  input wire logic             psel,                // apb select
  input wire logic             penable,             // apb enable
  input wire logic             pready,              // apb ready
  input wire logic             pslverr,             // apb error
  input wire ffs_pkg::sense_s  sense_raw,           // comparators
  input wire logic [CUR_W-1:0] current_code,        // load adc
  input wire logic [CUR_W-1:0] current_reference_pin_code,           // reference adc
  input wire logic             gate_drive_on,       // gate
  input wire logic             fault_output_n,      // fault pin
  input wire logic             smb_alert_n,         // alert
  input wire logic             irq,                 // interrupt
  input wire logic             power_good_output,   // power good
  input wire logic [CUR_W-1:0] load_current_monitor // monitor
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_wait;
    psel && penable && !pready;
  endsequence
  sequence s_gd;
    (sense_raw.gate_near_vin && !gate_drive_on) [*2];
  endsequence
  sequence s_spf;
    (sense_raw.backup_oc && !sense_raw.current_reference_pin_gnd && gate_drive_on &&
     current_code <= current_reference_pin_code) [*3];
  endsequence
  a_pready_pulse: assert property (pready |=> !pready)
    else $error("pready held past one cycle");
  a_pready_wait: assert property (s_wait |=> pready)
    else $error("pready missing after access");
  a_slverr_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_irq_alert: assert property (irq == !smb_alert_n)
    else $error("irq and alert disagree");
  a_load_current_monitor_inrush: assert property (!power_good_output &&
      !$past(power_good_output) |-> load_current_monitor == '0)
    else $error("monitor nonzero outside steady state");
  a_fault_gate: assert property ($fell(fault_output_n)
      |-> ##[0:3] !gate_drive_on)
    else $error("gate left on after fault");
  a_gd_alert: assert property (s_gd |-> ##[1:6] !smb_alert_n)
    else $error("gate-drain short not flagged");
  a_spf_trip: assert property (s_spf |-> ##[0:4] !gate_drive_on)
    else $error("backup overcurrent did not trip");
  a_ot_off: assert property (sense_raw.tj_over [*3]
      |-> ##[0:4] !gate_drive_on)
    else $error("overtemperature did not shut down");
endmodule

bind fet_fault_supervisor fet_fault_supervisor_asserts #(.CUR_W(CUR_W))
  chk_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .sense_raw(sense_raw),
  .current_code(current_code), .current_reference_pin_code(current_reference_pin_code),
  .gate_drive_on(gate_drive_on), .fault_output_n(fault_output_n),
  .smb_alert_n(smb_alert_n), .irq(irq),
  .power_good_output(power_good_output),
  .load_current_monitor(load_current_monitor));

/* test/fet_stage_model.sv */
// power stage stand-in: gate rise, output and fet shorts
// sampled on pclk; the bench picks lag and fault modes
`timescale 1ns/1ps
module fet_stage_model (
  input  wire logic       pclk,      // clock
  input  wire logic       gate_on,   // gate drive
  input  wire logic [3:0] lag,       // gate rise cycles
  input  wire logic       gs_short,  // gate never rises
  input  wire logic       ds_short,  // output held at input
  input  wire logic       gd_short,  // gate tied to input
  output logic            gs_ok,     // overdrive reached
  output logic            vds_small, // vin close to vout
  output logic            vout_low,  // output discharged
  output logic            near_vin   // gate near input
);
  logic [3:0] cnt_q;
  always_ff @(posedge pclk) begin
    cnt_q <= !gate_on ? 4'h0 : (cnt_q == 4'hF ? cnt_q : cnt_q + 4'h1);
  end
  assign gs_ok     = gate_on && !gs_short && cnt_q >= lag;
  assign vds_small = ds_short;
  assign vout_low  = !ds_short && !gate_on;
  assign near_vin  = gd_short;
endmodule

/* test/testbench.sv */
// self-checking bench for the fet fault supervisor
// apb master tasks, power stage model, shortened timers
`timescale 1ns/1ps
`include "fet_fault_supervisor_defines.svh"
module testbench;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pready, pslverr, gate_drive_on, discharge_en;
  logic fault_output_n, smb_alert_n, irq, power_good_output;
  logic [7:0]  paddr = 8'h00, temp_code = 8'h10;
  logic [31:0] pwdata = 32'h0, prdata, seed = 32'hE786;
  logic [11:0] current_code = 12'h0, current_reference_pin_code = 12'h800;
  logic [11:0] load_current_monitor;
  logic [3:0]  gpio_i = 4'h0, gpio_o, gpio_oe, lag = 4'h3;
  logic boc = 1'b0, ignd = 1'b0, tj = 1'b0, c1 = 1'b0, c2 = 1'b0;
  logic gs_short = 1'b0, ds_short = 1'b0, gd_short = 1'b0;
  logic vds, vlow, nvin, gsok;
  logic [31:0] r;
  logic e;
  int n_errors = 0, check_count = 0;
  ffs_pkg::sense_s sense_raw;
  assign sense_raw = {1'b1, boc, ignd, tj, vds, vlow, nvin, gsok, c1, c2};
  always #5 pclk = ~pclk;
  fet_fault_supervisor #(.SU_TMR_CYC(50), .DS_TMR_CYC(40),
    .RETRY_CYC(100)) fet_fault_supervisor_i (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .sense_raw, .temp_code, .current_code, .current_reference_pin_code, .gpio_i, .gpio_o,
    .gpio_oe, .gate_drive_on, .discharge_en, .fault_output_n,
    .smb_alert_n, .irq, .power_good_output, .load_current_monitor);
  fet_stage_model fet_stage_model_i (.pclk, .gate_on(gate_drive_on),
    .lag, .gs_short, .ds_short, .gd_short, .gs_ok(gsok),
    .vds_small(vds), .vout_low(vlow), .near_vin(nvin));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [31:0] flag_of(input int k);
    case (k)
      0: return 32'h1 << `FFS_ST_GS;
      1: return 32'h1 << `FFS_ST_DS;
      2: return 32'h1 << `FFS_ST_GD;
      3: return 32'h1 << `FFS_ST_SPF;
      4: return 32'h1 << `FFS_ST_OT;
      default: return 32'h1 << `FFS_ST_OC;
    endcase
  endfunction
  task automatic stop_test();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic check(input string s, input logic [31:0] g,
                       input logic [31:0] x);
    check_count++;
    if (g !== x) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", s, x, g);
    end
  endtask
  // one transfer; prdata and pslverr taken at the pready edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    r = prdata;
    e = pslverr;
    check("pready", pready, 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    check("read data", r, x);
    check("slverr", e, 1'b0);
  endtask
  task automatic wait_lvl(ref logic s, input logic v, input string nm);
    int n;
    n = 0;
    while (s !== v && n < 2000) begin
      @(negedge pclk);
      n++;
    end
    check(nm, s, v);
    @(posedge pclk);
  endtask
  task automatic inject(input int k, input logic on);
    case (k)
      0: gs_short <= on;
      1: ds_short <= on;
      2: gd_short <= on;
      3: boc <= on;
      4: wr(`FFS_OFF_OT_THR, on ? {24'h0, temp_code} : 32'hFF);
      default: ignd <= on;
    endcase
  endtask
  initial begin
    #1000000;
    n_errors++;
    stop_test();
  end
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    gpio_i <= 4'(rnd());
    c1 <= 1'(rnd());
    @(posedge pclk);
    rd(`FFS_OFF_CTRL, 32'h1);
    rd(`FFS_OFF_STATUS, 32'h0);
    rd(`FFS_OFF_IRQ_MASK, 32'h0);
    rd(`FFS_OFF_OT_THR, 32'hFF);
    rd(`FFS_OFF_TEMP, 32'h10);
    rd(`FFS_OFF_GPIO_DATA, {24'h0, gpio_i, 4'hF});
    apb(1'b0, 8'h24, 32'h0);
    check("unmapped", e, 1'b1);
    for (int f = 0; f < 10; f++) begin
      wr(`FFS_OFF_GPIO_CFG, f * 32'h1111);
      rd(`FFS_OFF_GPIO_CFG, f * 32'h1111);
    end
    wr(`FFS_OFF_GPIO_CFG, 32'h5032);
    // start each case from off so start-up checks are reached
    wr(`FFS_OFF_CTRL, 32'h8);
    for (int k = 0; k < 6; k++) begin
      temp_code <= 8'(rnd()) & 8'h7F;
      lag <= 4'(rnd() % 15 + 1);
      current_code <= (12'(rnd()) & 12'h7FF) | 12'h1;
      if (k < 3) inject(k, 1'b1);
      wr(`FFS_OFF_CTRL, 32'h1);
      if (k == 1) wait_lvl(discharge_en, 1'b1, "discharge");
      if (k >= 3) begin
        wait_lvl(power_good_output, 1'b1, "pgood");
        check("monitor", load_current_monitor, current_code);
        check("pins", {gpio_oe, gpio_o}, 32'h22);
        rd(`FFS_OFF_STATE, 32'h1C);
        inject(k, 1'b1);
      end
      wait_lvl(fault_output_n, 1'b0, "fault pin");
      wait_lvl(gate_drive_on, 1'b0, "gate");
      check("fault pin oe", gpio_oe[0], 1'b1);
      inject(k, 1'b0);
      rd(`FFS_OFF_STATUS, flag_of(k));
      wr(`FFS_OFF_STATUS, 32'h3F);
      rd(`FFS_OFF_STATUS, 32'h0);
      wr(`FFS_OFF_CTRL, 32'h8);
    end
    // gate-source drop in steady state, filtered for ten microseconds
    wr(`FFS_OFF_CTRL, 32'h1);
    wait_lvl(power_good_output, 1'b1, "pgood");
    gs_short <= 1'b1;
    repeat (950) @(posedge pclk);
    check("early fault", fault_output_n, 1'b1);
    wait_lvl(fault_output_n, 1'b0, "gs fault");
    rd(`FFS_OFF_STATUS, flag_of(0));
    gs_short <= 1'b0;
    wr(`FFS_OFF_STATUS, 32'h3F);
    wr(`FFS_OFF_CTRL, 32'h8);
    ds_short <= 1'b1;
    wr(`FFS_OFF_CTRL, 32'h5);
    wait_lvl(power_good_output, 1'b1, "precharged");
    rd(`FFS_OFF_STATUS, 32'h0);
    ds_short <= 1'b0;
    wr(`FFS_OFF_CTRL, 32'h8);
    wr(`FFS_OFF_IRQ_MASK, 32'h3F);
    wr(`FFS_OFF_CTRL, 32'h1);
    wait_lvl(power_good_output, 1'b1, "pgood");
    inject(4, 1'b1);
    wait_lvl(fault_output_n, 1'b0, "masked fault");
    check("masked irq", irq, 1'b0);
    wr(`FFS_OFF_IRQ_MASK, 32'h0);
    wait_lvl(irq, 1'b1, "irq");
    inject(4, 1'b0);
    wr(`FFS_OFF_STATUS, 32'h3F);
    wait_lvl(irq, 1'b0, "irq clear");
    wr(`FFS_OFF_CTRL, 32'h8);
    for (int rt = 0; rt < 2; rt++) begin
      wr(`FFS_OFF_CTRL, 32'h1 | (rt << 1));
      wait_lvl(power_good_output, 1'b1, "pgood");
      tj <= 1'b1;
      repeat (5) @(posedge pclk);
      tj <= 1'b0;
      wait_lvl(gate_drive_on, 1'b0, "thermal off");
      if (rt == 1) wait_lvl(power_good_output, 1'b1, "retry");
      else begin
        repeat (300) @(posedge pclk);
        check("latched", power_good_output, 1'b0);
      end
      rd(`FFS_OFF_STATUS, flag_of(4));
      wr(`FFS_OFF_STATUS, 32'h3F);
      wr(`FFS_OFF_CTRL, 32'h8);
    end
    stop_test();
  end
endmodule
